/* core/cifs_pkg.sv */
// Overview of operation
// - each hardware-settable interrupt flag is set only by the controller and holds until software clears it.
// - a CAN bus error sets the bus error flag at bit 13 of the low interrupt register.
// - an internal system error sets the system error flag at bit 12 of the low interrupt register.
// - when the current mode becomes equal to the requested mode the mode change flag at bit 3 sets.
// - a time base counter overflow sets the timebase overflow flag at bit 2.
// - a 32-bit base address split over high and low registers locates the event FIFO and objects.
// - the aborted bit at bit 7 reads 1 after an aborted transmission and 0 after a successful one.
// - lost arbitration and transmit error bits change only on completion, abort or FIFO reset.
// - the aborted bit is reset by any read of the FIFO status register and by a queue reset.
// - the aborted bit is also cleared when a transmit request is set or by a serial write.
// - in receive direction the overflow flag at bit 3 sets on overflow; in transmit it reads 0.
package cifs_pkg;
  // ------------------------------------------------------------
  // register word addresses
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_INT_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_INT_MASK = 4'h1;
  localparam logic [3:0] ADDR_BASE_HIGH = 4'h2;
  localparam logic [3:0] ADDR_BASE_LOW = 4'h3;
  localparam logic [3:0] ADDR_FIFO_STATUS = 4'h4;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_INVALID_MSG = 15;
  localparam int BIT_WAKEUP = 14;
  localparam int BIT_BUS_ERR = 13;
  localparam int BIT_SYS_ERR = 12;
  localparam int BIT_MODE_CHG = 3;
  localparam int BIT_TB_OVF = 2;
  localparam int BIT_ABORTED = 7;
  localparam int BIT_LOST_ARB = 6;
  localparam int BIT_TX_ERR = 5;
  localparam int BIT_RX_OVF = 3;
  localparam int IDX_LSB = 8;
  localparam logic [15:0] INT_SET_MASK = 16'hf00c;
  localparam logic [15:0] RESET_ZERO = 16'h0000;
  localparam int MODE_W = 3;
  localparam int IDX_W = 5;
  // ------------------------------------------------------------
  // event carrier
  // ------------------------------------------------------------
  typedef struct packed {
    logic invalidMsg;
    logic busWakeup;
    logic busError;
    logic systemError;
    logic timebaseOverflow;
  } cifs_events_t;
  typedef struct packed {
    logic txDone;
    logic txAbort;
    logic lostArb;
    logic txError;
    logic fifoReset;
    logic queueReset;
    logic txRequestSet;
    logic serialWriteClr;
    logic rxOverflow;
    logic advance;
  } cifs_fifo_ev_t;
endpackage : cifs_pkg

/* core/cifs_top.sv */
`timescale 1ns/10ps
module cifs_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire cifs_pkg::cifs_events_t events,
  input wire cifs_pkg::cifs_fifo_ev_t fifoEvents,
  input wire logic fifoDirectionTransmit,
  input wire logic [cifs_pkg::MODE_W-1:0] currentOperatingMode,
  input wire logic [cifs_pkg::MODE_W-1:0] requestedOperatingMode,
  output logic [31:0] messageMemoryBase,
  output logic irq
);
  import cifs_pkg::*;

  logic [1:0] rstSync_q;
  logic rstn;
  logic [15:0] intFlags_q;
  logic [15:0] intMask_q;
  logic [15:0] baseHigh_q;
  logic [15:0] baseLow_q;
  logic aborted_q;
  logic lostArb_q;
  logic transmit_error_status_q;
  logic rxOvf_q;
  logic [IDX_W-1:0] msgIndex_q;
  logic [MODE_W-1:0] modePrev_q;
  logic ack_q;
  logic [15:0] intSet_d;
  logic [15:0] fifoStatus;
  logic wrStrobe;
  logic rdStrobe;
  logic modeMatch;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  // two stages so release never lands near an edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstn = rstSync_q[1];

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // one wait cycle per access; strobes fire on the acknowledging edge
  assign wrStrobe = avs_write && ack_q;
  assign rdStrobe = avs_read && ack_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end
  // registered copy of the inverse of the next ack, so the pin comes from a flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

  // ------------------------------------------------------------
  // interrupt flags
  // ------------------------------------------------------------
  // mode change counts only on the cycle the current mode changes to equal the requested mode
  assign modeMatch = (currentOperatingMode == requestedOperatingMode)
                     && (modePrev_q != currentOperatingMode);
  always_comb begin
    intSet_d = RESET_ZERO;
    intSet_d[BIT_INVALID_MSG] = events.invalidMsg;
    intSet_d[BIT_WAKEUP] = events.busWakeup;
    intSet_d[BIT_BUS_ERR] = events.busError;
    intSet_d[BIT_SYS_ERR] = events.systemError;
    intSet_d[BIT_MODE_CHG] = modeMatch;
    intSet_d[BIT_TB_OVF] = events.timebaseOverflow;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      modePrev_q <= '0;
    end else begin
      modePrev_q <= currentOperatingMode;
    end
  end
  // write-one-to-clear; a set in the same cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intFlags_q <= RESET_ZERO;
    end else begin
      if (wrStrobe && avs_address == ADDR_INT_FLAGS) begin
        intFlags_q <= ((intFlags_q & ~avs_writedata[15:0]) | intSet_d) & INT_SET_MASK;
      end else begin
        intFlags_q <= (intFlags_q | intSet_d) & INT_SET_MASK;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intMask_q <= RESET_ZERO;
    end else if (wrStrobe && avs_address == ADDR_INT_MASK) begin
      intMask_q <= avs_writedata[15:0] & INT_SET_MASK;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intFlags_q & intMask_q);
    end
  end

  // ------------------------------------------------------------
  // message memory base
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      baseHigh_q <= RESET_ZERO;
      baseLow_q <= RESET_ZERO;
    end else if (wrStrobe) begin
      if (avs_address == ADDR_BASE_HIGH) begin
        baseHigh_q <= avs_writedata[15:0];
      end
      if (avs_address == ADDR_BASE_LOW) begin
        baseLow_q <= avs_writedata[15:0];
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      messageMemoryBase <= '0;
    end else begin
      messageMemoryBase <= {baseHigh_q, baseLow_q};
    end
  end

  // ------------------------------------------------------------
  // transmit outcome status
  // ------------------------------------------------------------
  // outcome event beats the clears of the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aborted_q <= 1'b0;
    end else if (fifoEvents.txAbort) begin
      aborted_q <= 1'b1;
    end else if (fifoEvents.txDone) begin
      aborted_q <= 1'b0;
    end else if ((rdStrobe && avs_address == ADDR_FIFO_STATUS) || fifoEvents.queueReset) begin
      aborted_q <= 1'b0;
    end else if (fifoEvents.txRequestSet || fifoEvents.serialWriteClr) begin
      aborted_q <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lostArb_q <= 1'b0;
      transmit_error_status_q <= 1'b0;
    end else if (fifoEvents.fifoReset) begin
      lostArb_q <= 1'b0;
      transmit_error_status_q <= 1'b0;
    end else if (fifoEvents.txDone || fifoEvents.txAbort) begin
      lostArb_q <= fifoEvents.lostArb;
      transmit_error_status_q <= fifoEvents.txError;
    end
  end

  // ------------------------------------------------------------
  // receive overflow and message index
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxOvf_q <= 1'b0;
    end else if (fifoDirectionTransmit || fifoEvents.fifoReset) begin
      rxOvf_q <= 1'b0;
    end else if (fifoEvents.rxOverflow) begin
      rxOvf_q <= 1'b1;
    end else if (wrStrobe && avs_address == ADDR_FIFO_STATUS && avs_writedata[BIT_RX_OVF]) begin
      rxOvf_q <= 1'b0;
    end
  end
  // index wraps at the field width; sizing to a shallower fifo is left outside
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      msgIndex_q <= '0;
    end else if (fifoEvents.fifoReset) begin
      msgIndex_q <= '0;
    end else if (fifoEvents.advance) begin
      msgIndex_q <= msgIndex_q + 5'h01;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_comb begin
    fifoStatus = RESET_ZERO;
    fifoStatus[IDX_LSB +: IDX_W] = msgIndex_q;
    fifoStatus[BIT_ABORTED] = aborted_q;
    fifoStatus[BIT_LOST_ARB] = lostArb_q;
    fifoStatus[BIT_TX_ERR] = transmit_error_status_q;
    fifoStatus[BIT_RX_OVF] = rxOvf_q && !fifoDirectionTransmit;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack_q) begin
      unique case (avs_address)
        ADDR_INT_FLAGS: avs_readdata <= {16'h0000, intFlags_q};
        ADDR_INT_MASK: avs_readdata <= {16'h0000, intMask_q};
        ADDR_BASE_HIGH: avs_readdata <= {16'h0000, baseHigh_q};
        ADDR_BASE_LOW: avs_readdata <= {16'h0000, baseLow_q};
        ADDR_FIFO_STATUS: avs_readdata <= {16'h0000, fifoStatus};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule : cifs_top

/* verification/cifs_bus_model.sv */
`timescale 1ns/10ps
module cifs_bus_model import cifs_pkg::*; (
  input wire logic clk,
  input wire logic [4:0] kick,
  output cifs_pkg::cifs_events_t events
);
  // one-cycle event pulse per kick, one cycle late as if seen on the wire
  always_ff @(posedge clk) begin
    events <= kick;
  end
endmodule : cifs_bus_model

/* verification/cifs_chk.sv */
`timescale 1ns/10ps
module cifs_chk import cifs_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic fifoDirectionTransmit,
  input wire logic [31:0] messageMemoryBase,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rq;
  logic rdOk;
  assign rq = avs_read | avs_write;
  assign rdOk = avs_read & !avs_waitrequest;
  ack_turn_a: assert property (rq && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  ack_one_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low twice");
  ack_cause_a: assert property ($fell(avs_waitrequest) |-> $past(rq)) else $error("stray answer");
  rd_upper_a: assert property (rdOk |-> avs_readdata[31:16] == 16'h0) else $error("upper not 0");
  int_resv_a: assert property (rdOk && avs_address == ADDR_INT_FLAGS |->
    (avs_readdata[15:0] & ~INT_SET_MASK) == 16'h0) else $error("flag reserved set");
  fifo_resv_a: assert property (rdOk && avs_address == ADDR_FIFO_STATUS |->
    avs_readdata[15:13] == 3'h0) else $error("status reserved set");
  rxovf_tx_a: assert property (rdOk && avs_address == ADDR_FIFO_STATUS &&
    fifoDirectionTransmit && $past(fifoDirectionTransmit, 2) |-> !avs_readdata[BIT_RX_OVF])
    else $error("overflow in transmit");
  base_high_a: assert property (avs_write && !avs_waitrequest &&
    avs_address == ADDR_BASE_HIGH |=> ##2 messageMemoryBase[31:16] == $past(avs_writedata[15:0], 3))
    else $error("base high wrong");
  mask_off_a: assert property (avs_write && !avs_waitrequest &&
    avs_address == ADDR_INT_MASK && avs_writedata[15:0] == 16'h0 |=> ##2 !irq)
    else $error("irq despite mask");
  cover property (rdOk && avs_address == ADDR_FIFO_STATUS && avs_readdata[BIT_ABORTED]);
  cover property (rdOk && avs_address == ADDR_FIFO_STATUS && avs_readdata[BIT_RX_OVF]);
  cover property ($rose(irq));
endmodule : cifs_chk
bind cifs_top cifs_chk u_cifs_chk (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .fifoDirectionTransmit,
  .messageMemoryBase, .irq);

/* verification/cifs_top_tb.sv */
`timescale 1ns/10ps
module cifs_top_tb;
  import cifs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, messageMemoryBase;
  logic avs_waitrequest, irq;
  logic fifoDirectionTransmit = 1'b0;
  logic [MODE_W-1:0] currentOperatingMode = 3'h0;
  logic [MODE_W-1:0] requestedOperatingMode = 3'h0;
  logic [4:0] kick = 5'h0;
  cifs_events_t events;
  cifs_fifo_ev_t fifoEvents = '0;
  logic [15:0] q;
  int fail_count = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  cifs_bus_model u_cifs_bus_model (.clk, .kick, .events);
  cifs_top u_cifs_top (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .events, .fifoEvents, .fifoDirectionTransmit,
    .currentOperatingMode, .requestedOperatingMode, .messageMemoryBase, .irq);
  // ----------------------------------------
  // bus tasks, driven and sampled on the rising edge
  // ----------------------------------------
  task end_of_test;
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      $display("CHECK FAILED at %0t: bus timeout", $time);
      fail_count++;
      end_of_test();
    end
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task rd(input logic [3:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0);
    chk(q, exp);
  endtask : rd
  // fifo event bits: 9 done, 8 abort, 7 lostArb, 6 transmit_error_status, 4 queue, 3 req, 2 serial, 1 ovf, 0 adv
  task pulse(input logic [4:0] k, input logic [9:0] f);
    @(posedge clk);
    kick <= k;
    fifoEvents <= f;
    @(posedge clk);
    kick <= 5'h0;
    fifoEvents <= '0;
    repeat (2) @(posedge clk);
  endtask : pulse
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int fb [5] = '{2, 12, 13, 14, 15};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 8; a++) rd(a[3:0], 16'h0);
    bus(1'b1, 4'h7, 16'hffff);
    rd(4'h7, 16'h0);
    bus(1'b1, ADDR_INT_FLAGS, 16'hffff);
    rd(ADDR_INT_FLAGS, 16'h0);
    for (int i = 0; i < 5; i++) begin
      pulse(5'h1 << i, 10'h0);
      rd(ADDR_INT_FLAGS, 16'h1 << fb[i]);
      rd(ADDR_INT_FLAGS, 16'h1 << fb[i]);
      bus(1'b1, ADDR_INT_FLAGS, 16'h1 << fb[i]);
      rd(ADDR_INT_FLAGS, 16'h0);
    end
    requestedOperatingMode <= 3'h2;
    pulse(5'h0, 10'h0);
    rd(ADDR_INT_FLAGS, 16'h0);
    currentOperatingMode <= 3'h2;
    pulse(5'h0, 10'h0);
    rd(ADDR_INT_FLAGS, 16'h0008);
    bus(1'b1, ADDR_INT_FLAGS, 16'h0008);
    // irq follows flag and mask as a level
    bus(1'b1, ADDR_INT_MASK, 16'h2000);
    pulse(5'h04, 10'h0);
    @(negedge clk);
    chk({15'h0, irq}, 16'h1);
    bus(1'b1, ADDR_INT_MASK, 16'h0);
    @(posedge clk);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0);
    bus(1'b1, ADDR_INT_MASK, 16'h2000);
    @(posedge clk);
    @(negedge clk);
    chk({15'h0, irq}, 16'h1);
    bus(1'b1, ADDR_INT_FLAGS, 16'h2000);
    @(posedge clk);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0);
    bus(1'b1, ADDR_BASE_HIGH, 16'h1234);
    bus(1'b1, ADDR_BASE_LOW, 16'h5678);
    rd(ADDR_BASE_HIGH, 16'h1234);
    rd(ADDR_BASE_LOW, 16'h5678);
    chk(messageMemoryBase[31:16], 16'h1234);
    chk(messageMemoryBase[15:0], 16'h5678);
    // receive direction: overflow and slot index
    pulse(5'h0, 10'h002);
    rd(ADDR_FIFO_STATUS, 16'h0008);
    bus(1'b1, ADDR_FIFO_STATUS, 16'h0008);
    rd(ADDR_FIFO_STATUS, 16'h0);
    repeat (3) pulse(5'h0, 10'h001);
    rd(ADDR_FIFO_STATUS, 16'h0300);
    // transmit direction: outcome bits and their clears
    fifoDirectionTransmit <= 1'b1;
    pulse(5'h0, 10'h180);
    rd(ADDR_FIFO_STATUS, 16'h03c0);
    rd(ADDR_FIFO_STATUS, 16'h0340);
    for (int i = 2; i < 5; i++) begin
      pulse(5'h0, 10'h180);
      pulse(5'h0, 10'h1 << i);
      rd(ADDR_FIFO_STATUS, 16'h0340);
    end
    pulse(5'h0, 10'h240);
    rd(ADDR_FIFO_STATUS, 16'h0320);
    pulse(5'h0, 10'h080);
    rd(ADDR_FIFO_STATUS, 16'h0320);
    pulse(5'h0, 10'h002);
    rd(ADDR_FIFO_STATUS, 16'h0320);
    end_of_test();
  end
endmodule : cifs_top_tb
